//--- logic/omc_device.sv
// Device end: power sequencing and operating-mode control of the sensor conditioner.
module omc_device (
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    input  wire logic  clk_en,
    omc_if.device      bus,
    input  wire logic  [15:0] nvm_cfg_word,
    output logic       [7:0]  nvm_cfg_addr,
    output logic              core_switched_domain,
    output logic              always_on_interface_domain,
    output logic              analog_ready,
    output logic              measure_strobe,
    output logic       [1:0]  op_mode,
    output logic       [15:0] result_data
);
    typedef struct packed {
        omc_pkg::omc_state_e state;
        omc_pkg::omc_mode_e  mode;
        logic                first_cmd_seen;
        logic [2:0]          cycle_sleep_interval;
        logic [23:0]         timer;
        logic [23:0]         analog_timer;
        logic [7:0]          cur_cmd;
        logic [15:0]         cur_data;
        logic                rsp;
        logic [15:0]         result;
        logic                meas;
        logic [15:0]         sample;
    } omc_dev_s;

    omc_dev_s st_ff;
    omc_dev_s nxt_st;
    logic     accept;

    function automatic logic [23:0] cyc_interval(input logic [2:0] sel);
        cyc_interval = omc_pkg::BASE_INTERVAL << sel;
    endfunction : cyc_interval

    // Commands are taken only where the controller is listening.
    assign accept = bus.cmd_valid && omc_pkg::omc_cmd_valid(bus.cmd_code)
                    && (st_ff.state == omc_pkg::OMC_SLEEP || st_ff.state == omc_pkg::OMC_CAL_IDLE);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rsp = 1'b0;
        nxt_st.meas = 1'b0;
        if (st_ff.timer != 24'h00_0000) begin
            nxt_st.timer = st_ff.timer - 24'h00_0001;
        end
        if (st_ff.analog_timer != 24'h00_0000) begin
            nxt_st.analog_timer = st_ff.analog_timer - 24'h00_0001;
        end
        case (st_ff.state)
            omc_pkg::OMC_POWER_UP: begin
                nxt_st.state = omc_pkg::OMC_CFG_LOAD;
                nxt_st.timer = 24'(omc_pkg::CFG_LOAD_CYC);
                nxt_st.analog_timer = 24'(omc_pkg::STUP2_CYC);
            end
            omc_pkg::OMC_CFG_LOAD: begin
                if (st_ff.timer == 24'h00_0000) begin
                    nxt_st.cycle_sleep_interval =
                        nvm_cfg_word[omc_pkg::CYC_FIELD_MSB:omc_pkg::CYC_FIELD_LSB];
                    nxt_st.state = omc_pkg::OMC_SLEEP;
                end
            end
            omc_pkg::OMC_SLEEP: begin
                if (accept) begin
                    nxt_st.cur_cmd = bus.cmd_code;
                    nxt_st.cur_data = bus.cmd_data;
                    nxt_st.state = omc_pkg::OMC_WAKE;
                    nxt_st.timer = 24'(omc_pkg::CMD_EXEC_CYC);
                    nxt_st.analog_timer = 24'(omc_pkg::WUP2_CYC);
                end else if (st_ff.mode == omc_pkg::OMC_MODE_CYCLIC && st_ff.timer == 24'h00_0000) begin
                    nxt_st.cur_cmd = omc_pkg::CMD_MEASURE;
                    nxt_st.state = omc_pkg::OMC_WAKE;
                    nxt_st.timer = 24'(omc_pkg::CMD_EXEC_CYC);
                    nxt_st.analog_timer = 24'(omc_pkg::WUP2_CYC);
                end
            end
            omc_pkg::OMC_CAL_IDLE: begin
                if (accept) begin
                    nxt_st.cur_cmd = bus.cmd_code;
                    nxt_st.cur_data = bus.cmd_data;
                    nxt_st.state = omc_pkg::OMC_WAKE;
                    nxt_st.timer = 24'(omc_pkg::CMD_EXEC_CYC);
                end
            end
            omc_pkg::OMC_WAKE: begin
                if (st_ff.timer == 24'h00_0000) begin
                    nxt_st.state = omc_pkg::OMC_EXEC;
                    if (st_ff.cur_cmd >= omc_pkg::CMD_NVM_WRITE && st_ff.cur_cmd <= omc_pkg::CMD_NVM_WR_TOP) begin
                        nxt_st.timer = 24'(omc_pkg::PROG_CYC);
                    end else if (st_ff.cur_cmd == omc_pkg::CMD_MEASURE) begin
                        nxt_st.timer = 24'(omc_pkg::UPDATE_CYC);
                    end else begin
                        nxt_st.timer = 24'h00_0000;
                    end
                end
            end
            omc_pkg::OMC_EXEC: begin
                if (st_ff.timer == 24'h00_0000) begin
                    nxt_st.rsp = 1'b1;
                    if (st_ff.cur_cmd == omc_pkg::CMD_MEASURE) begin
                        nxt_st.meas = 1'b1;
                        nxt_st.sample = st_ff.sample + 16'h0001;
                        nxt_st.result = st_ff.sample + 16'h0001;
                    end else begin
                        nxt_st.result = {8'h00, st_ff.cur_cmd};
                    end
                    if (st_ff.cur_cmd == omc_pkg::CMD_ENTER_CAL && st_ff.mode == omc_pkg::OMC_MODE_SLEEP
                        && !st_ff.first_cmd_seen) begin
                        nxt_st.mode = omc_pkg::OMC_MODE_CAL;
                    end else if (st_ff.cur_cmd == omc_pkg::CMD_RESUME_NORM) begin
                        nxt_st.mode = omc_pkg::OMC_MODE_SLEEP;
                    end else if (st_ff.cur_cmd == omc_pkg::CMD_START_CYC) begin
                        nxt_st.mode = omc_pkg::OMC_MODE_CYCLIC;
                    end
                    // The flag is set only once the first command has finished, so that command still sees it clear.
                    nxt_st.first_cmd_seen = 1'b1;
                    nxt_st.state = omc_pkg::OMC_SLEEP;
                    nxt_st.timer = cyc_interval(st_ff.cycle_sleep_interval);
                    if (nxt_st.mode == omc_pkg::OMC_MODE_CAL) begin
                        nxt_st.state = omc_pkg::OMC_CAL_IDLE;
                        nxt_st.timer = 24'h00_0000;
                    end
                end
            end
            default: nxt_st.state = omc_pkg::OMC_POWER_UP;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign bus.cmd_ready = accept;
    assign bus.rsp_valid = st_ff.rsp;
    assign bus.rsp_data  = st_ff.result;
    assign bus.dev_ready = (st_ff.state == omc_pkg::OMC_SLEEP) || (st_ff.state == omc_pkg::OMC_CAL_IDLE);
    assign nvm_cfg_addr  = omc_pkg::CFG_CYC_ADDR;
    assign core_switched_domain = (st_ff.state != omc_pkg::OMC_SLEEP);
    assign always_on_interface_domain = 1'b1;
    assign analog_ready  = core_switched_domain && (st_ff.analog_timer == 24'h00_0000)
                           && (st_ff.state != omc_pkg::OMC_POWER_UP) && (st_ff.state != omc_pkg::OMC_CFG_LOAD);
    assign measure_strobe = st_ff.meas;
    assign op_mode       = st_ff.mode;
    assign result_data   = st_ff.result;
endmodule : omc_device

//--- logic/omc_host.sv
// Host end: issues commands to the mode controller after the required delays.
module omc_host (
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    input  wire logic  clk_en,
    omc_if.host        bus,
    input  wire logic         req_valid,
    input  wire logic  [7:0]  req_code,
    input  wire logic  [15:0] req_data,
    output logic              req_ready,
    output logic              ans_valid,
    output logic       [15:0] ans_data
);
    typedef struct packed {
        logic [23:0] wait_cnt;
        logic        pending;
        logic [7:0]  code;
        logic [15:0] data;
        logic        ans;
        logic [15:0] ans_word;
        logic        was_ready;
        logic        took;
    } omc_host_s;

    omc_host_s st_ff;
    omc_host_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ans = 1'b0;
        nxt_st.was_ready = bus.dev_ready;
        nxt_st.took = st_ff.pending && bus.cmd_ready;
        if (st_ff.wait_cnt != 24'h00_0000) begin
            nxt_st.wait_cnt = st_ff.wait_cnt - 24'h00_0001;
        end
        // Only an autonomous wake arms the delay; a wake caused by our own command already carries that command.
        if (st_ff.was_ready && !bus.dev_ready && !st_ff.took) begin
            nxt_st.wait_cnt = 24'(omc_pkg::WUP1_CYC);
        end
        if (!st_ff.pending && req_valid && st_ff.wait_cnt == 24'h00_0000) begin
            nxt_st.pending = 1'b1;
            nxt_st.code = req_code;
            nxt_st.data = req_data;
        end else if (st_ff.pending && bus.cmd_ready) begin
            nxt_st.pending = 1'b0;
        end
        if (bus.rsp_valid) begin
            nxt_st.ans = 1'b1;
            nxt_st.ans_word = bus.rsp_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= '0;
            st_ff.wait_cnt <= 24'(omc_pkg::STUP1_CYC);
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign bus.cmd_valid = st_ff.pending && st_ff.wait_cnt == 24'h00_0000 && bus.dev_ready;
    assign bus.cmd_code  = st_ff.code;
    assign bus.cmd_data  = st_ff.data;
    assign req_ready     = !st_ff.pending && st_ff.wait_cnt == 24'h00_0000;
    assign ans_valid     = st_ff.ans;
    assign ans_data      = st_ff.ans_word;
endmodule : omc_host

//--- logic/omc_if.sv
// Interface joining the host end and the device end of the mode controller.
interface omc_if;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_data;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        dev_ready;

    modport device (
        input  cmd_valid, cmd_code, cmd_data,
        output cmd_ready, rsp_valid, rsp_data, dev_ready
    );
    modport host (
        output cmd_valid, cmd_code, cmd_data,
        input  cmd_ready, rsp_valid, rsp_data, dev_ready
    );
endinterface : omc_if

//--- logic/omc_pkg.sv
// Package with shared constants and types of the operating-mode controller.
package omc_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned STUP1_US        = 1000;
    localparam int unsigned STUP2_US        = 2500;
    localparam int unsigned WUP1_US         = 500;
    localparam int unsigned WUP2_US         = 2000;
    localparam int unsigned PROG_MS         = 20;
    localparam int unsigned UPDATE_HZ       = 290;
    localparam int unsigned STUP1_CYC       = STUP1_US * (CLK_HZ / 1_000_000);
    localparam int unsigned STUP2_CYC       = STUP2_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WUP1_CYC        = WUP1_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WUP2_CYC        = WUP2_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PROG_CYC        = PROG_MS * (CLK_HZ / 1000);
    localparam int unsigned UPDATE_CYC      = CLK_HZ / UPDATE_HZ;
    localparam int unsigned CFG_LOAD_CYC    = 16;
    localparam int unsigned CMD_EXEC_CYC    = 8;
    localparam int unsigned CYC_FIELD_LSB   = 12;
    localparam int unsigned CYC_FIELD_MSB   = 14;
    localparam logic [7:0]  CFG_CYC_ADDR    = 8'h02;
    localparam logic [7:0]  CMD_ENTER_CAL   = 8'hA9;
    localparam logic [7:0]  CMD_RESUME_NORM = 8'hA8;
    localparam logic [7:0]  CMD_MEASURE     = 8'hAA;
    localparam logic [7:0]  CMD_START_CYC   = 8'hAB;
    localparam logic [7:0]  CMD_NVM_WRITE   = 8'h40;
    localparam logic [7:0]  CMD_NVM_WR_TOP  = 8'h7F;
    localparam logic [15:0] CFG_RST_VAL     = 16'h0000;
    localparam logic [23:0] BASE_INTERVAL   = 24'h0F_4240;

    typedef enum logic [2:0] {
        OMC_POWER_UP = 3'b000,
        OMC_CFG_LOAD = 3'b001,
        OMC_SLEEP    = 3'b011,
        OMC_WAKE     = 3'b010,
        OMC_EXEC     = 3'b110,
        OMC_CAL_IDLE = 3'b111
    } omc_state_e;

    typedef enum logic [1:0] {
        OMC_MODE_SLEEP  = 2'h0,
        OMC_MODE_CYCLIC = 2'h1,
        OMC_MODE_CAL    = 2'h2
    } omc_mode_e;

    function automatic logic omc_cmd_valid(input logic [7:0] cmd);
        omc_cmd_valid = (cmd == CMD_ENTER_CAL) || (cmd == CMD_RESUME_NORM) || (cmd == CMD_MEASURE)
            || (cmd == CMD_START_CYC) || ((cmd >= CMD_NVM_WRITE) && (cmd <= CMD_NVM_WR_TOP));
    endfunction : omc_cmd_valid
endpackage : omc_pkg

//--- testbench/omc_props.sv
// Checker of the command handshake between the host end and the device end.
module omc_props (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic        cmd_ready,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic        dev_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic code_ok;
    logic quick;
    assign code_ok = (cmd_code inside {8'hA8, 8'hA9, 8'hAA, 8'hAB}) || (cmd_code inside {[8'h40:8'h7F]});
    assign quick   = cmd_code inside {8'hA8, 8'hA9, 8'hAB};
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    take_when_listening_a: assert property (cmd_ready |-> cmd_valid && dev_ready && code_ok)
        else $error("command taken while not listening");
    listen_accepts_a: assert property (cmd_valid && dev_ready && code_ok |-> cmd_ready)
        else $error("valid command not taken");
    bad_code_ignored_a: assert property (cmd_valid && dev_ready && !code_ok |-> !cmd_ready ##1 dev_ready)
        else $error("undefined code woke the device");
    power_up_seq_a: assert property ($fell(sys_rst) |-> !dev_ready [*8] ##[1:14] dev_ready)
        else $error("start-up sequence wrong");
    wake_busy_a: assert property (cmd_ready |=> !dev_ready [*8])
        else $error("device listening during execution");
    answer_time_a: assert property (cmd_ready && quick |-> ##[9:14] rsp_valid)
        else $error("answer late or missing");
    answer_pulse_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer pulse too long");
    back_to_idle_a: assert property (rsp_valid |-> ##[0:2] dev_ready)
        else $error("no return to idle after answer");
    answer_held_a: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("answer data changed without answer");
endmodule : omc_props

//--- testbench/testbench.sv
// Self-checking bench joining the host end and the device end of the mode controller.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk;
    logic        sys_rst;
    logic        req_valid;
    logic [7:0]  req_code;
    logic [15:0] req_data;
    logic        req_ready;
    logic        ans_valid;
    logic [15:0] ans_data;
    logic [7:0]  cfg_addr;
    logic        core_on;
    logic        aon_on;
    logic        analog_rdy;
    logic        meas_strobe;
    logic [1:0]  op_mode;
    logic [15:0] result;
    int          err_count;
    int          checks;

    omc_if bus_if ();
    omc_device omc_device_i (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .bus(bus_if.device),
        .nvm_cfg_word(16'h3000), .nvm_cfg_addr(cfg_addr), .core_switched_domain(core_on),
        .always_on_interface_domain(aon_on), .analog_ready(analog_rdy), .measure_strobe(meas_strobe),
        .op_mode(op_mode), .result_data(result));
    omc_host omc_host_i (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .bus(bus_if.host),
        .req_valid(req_valid), .req_code(req_code), .req_data(req_data), .req_ready(req_ready),
        .ans_valid(ans_valid), .ans_data(ans_data));
    omc_props omc_props_i (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(bus_if.cmd_valid),
        .cmd_code(bus_if.cmd_code), .cmd_ready(bus_if.cmd_ready), .rsp_valid(bus_if.rsp_valid),
        .rsp_data(bus_if.rsp_data), .dev_ready(bus_if.dev_ready));

    always #10 mclk = ~mclk;

    task automatic print_verdict();
        $display("Counts: %0d checks, %0d mismatches", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            err_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic give_up(input string msg);
        check(1'b0, msg);
        print_verdict();
    endtask : give_up

    // Holds the request until req_ready is seen high at the edge where the host takes it in (or 50 cycles pass), then waits for the answer if one is due.
    task automatic send(input logic [7:0] code, input bit answered);
        int n;
        n = 0;
        req_code  <= code;
        req_data  <= 16'h5A5A;
        req_valid <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        req_valid <= 1'b0;
        if (answered) begin
            if (n >= 50) give_up("request not taken");
            n = 0;
            while (ans_valid !== 1'b1 && n < 200) begin
                @(posedge mclk);
                n++;
            end
            if (n >= 200) give_up("no answer");
        end
        repeat (3) @(posedge mclk);
    endtask : send

    task automatic t_power_up();
        int n;
        n = 30;
        repeat (30) @(posedge mclk);
        check(bus_if.dev_ready === 1'b1, "not listening after load");
        check(core_on === 1'b0, "core still powered");
        check(op_mode === 2'h0 && aon_on === 1'b1, "bad idle state");
        check(cfg_addr === 8'h02, "wrong config word");
        check(req_ready === 1'b0, "host ready too early");
        while (req_ready !== 1'b1 && n < 60000) begin
            @(posedge mclk);
            n++;
        end
        check(n >= 49900 && n <= 50100, "host start-up wait wrong");
        $display("Test power_up done");
    endtask : t_power_up

    task automatic t_cal_entry();
        send(8'hA9, 1'b1);
        check(op_mode === 2'h2, "calibration mode not entered");
        check(ans_data === 16'h00A9, "wrong answer to entry command");
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            check(core_on === 1'b1 && meas_strobe === 1'b0, "calibration mode not held");
        end
        check(bus_if.dev_ready === 1'b1, "not listening in calibration");
        $display("Test cal_entry done");
    endtask : t_cal_entry

    task automatic t_resume();
        send(8'hA8, 1'b1);
        check(op_mode === 2'h0 && core_on === 1'b0, "no return to sleep");
        check(bus_if.dev_ready === 1'b1, "not listening in sleep");
        $display("Test resume done");
    endtask : t_resume

    task automatic t_late_cal();
        send(8'hA9, 1'b1);
        check(op_mode === 2'h0, "late entry command changed mode");
        check(core_on === 1'b0, "core left on after command");
        $display("Test late_cal done");
    endtask : t_late_cal

    task automatic t_cyclic_and_junk();
        send(8'hAB, 1'b1);
        check(op_mode === 2'h1, "cyclic mode not entered");
        send(8'h00, 1'b0);
        check(op_mode === 2'h1 && core_on === 1'b0, "undefined code acted");
        $display("Test cyclic_and_junk done");
    endtask : t_cyclic_and_junk

    initial begin
        mclk      = 1'b0;
        sys_rst   = 1'b1;
        req_valid = 1'b0;
        req_code  = 8'h00;
        req_data  = 16'h0000;
        err_count = 0;
        checks    = 0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        t_power_up();
        t_cal_entry();
        t_resume();
        t_late_cal();
        t_cyclic_and_junk();
        print_verdict();
    end
endmodule : testbench
